// file: src/sds_pkg.sv
package sds_pkg;

    // ****************************************************************
    // Register word indices on the plain register port.
    // ****************************************************************
    localparam logic [3:0] REG_CONFIG   = 4'h0;
    localparam logic [3:0] REG_VELOCITY = 4'h1;
    localparam logic [3:0] REG_CURRENT  = 4'h2;
    localparam logic [3:0] REG_STATUS   = 4'h3;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int CFG_DOUBLE_EDGE   = 0;
    localparam int CFG_PIN_DISABLE   = 1;
    localparam int CFG_CHOP_CYCLE    = 2;
    localparam int CFG_PDN_DISABLE   = 3;
    localparam int CFG_MRES_LSB      = 4;
    localparam int CFG_STILL_LSB     = 8;
    localparam int CUR_RUN_LSB       = 0;
    localparam int CUR_HOLD_LSB      = 8;
    localparam int CUR_DELAY_LSB     = 16;
    localparam int CUR_DECAY_LSB     = 24;
    localparam int STA_EXT_CLK       = 16;
    localparam int STA_SERIAL_EN     = 17;
    localparam int STA_STANDSTILL    = 18;
    localparam int STA_POWER_ON      = 19;

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [4:0] RST_RUN_SCALE   = 5'h1F;
    localparam logic [4:0] RST_HOLD_SCALE  = 5'h10;
    localparam logic [7:0] RST_DELAY       = 8'h14;
    localparam logic [3:0] RST_DECAY       = 4'h2;
    localparam logic [3:0] RST_MRES        = 4'h0;
    localparam logic [9:0] RST_POSITION    = 10'h000;

    // ****************************************************************
    // Timing: the clock rate, the units of the standstill timers and the external clock timeout.
    // ****************************************************************
    localparam int CLK_HZ           = 10_000_000;
    localparam int DELAY_UNIT_US    = 100;
    localparam int DELAY_UNIT_CYC   = (DELAY_UNIT_US * (CLK_HZ / 1_000_000));
    localparam int DECAY_UNIT_US    = 10;
    localparam int DECAY_UNIT_CYC   = (DECAY_UNIT_US * (CLK_HZ / 1_000_000));
    localparam int EXT_TIMEOUT_CYC  = 32;

    // Resolution codes: step size is 1 << code, code 8 is a fullstep.
    localparam logic [3:0] MRES_FULL = 4'h8;

    typedef enum logic [1:0]
    {
        STILL_REDUCE,
        STILL_FREEWHEEL,
        STILL_BRAKE,
        STILL_RESERVED
    } sds_still_t;

endpackage

// file: src/sds_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Rising step edges count, both if selected
// - Direction sampled at each active step edge
// - Direction low counts up, high counts down
// - Fullstep through 256 microsteps per fullstep
// - Table maps position to sine, cosine currents
// - Internal generator; velocity sign picks direction
// - New velocity applies at once, host ramps
// - External step edges count only while velocity is zero
// - Index pulse once per four fullsteps
// - Position is zero after reset
// - Powerdown pin low enables standstill reduction
// - Standstill current slightly above half run
// - Hold level, delay, decay are configurable
// - Freewheel or passive brake at standstill
// - External clock timeout falls back internal
// - First good frame enables serial; pins lockable
// - Baud detection lies outside this block
// - Four node addresses share one bus
// - Cycle chopper by pin or configuration
// - Pins 00,01,10,11 give 1/8,1/32,1/64,1/16
// - Disable pin high floats the power stage
module sds_sequencer
#(
    parameter int VEL_W       = 24,
    parameter int EXT_TIMEOUT = sds_pkg::EXT_TIMEOUT_CYC
)
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              step_in,
    input  wire logic              dir_in,
    input  wire logic              powerdown_serial_pin,
    input  wire logic              driver_disable_n,
    input  wire logic              resolution_select_0,
    input  wire logic              resolution_select_1,
    input  wire logic              chopper_select_pin,
    input  wire logic              ext_clk_in,
    input  wire logic [1:0]        bus_node,
    input  wire logic [3:0]        bus_addr,
    input  wire logic [31:0]       bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [31:0]       bus_rdata,
    output logic signed [8:0]      coil_a_current,
    output logic signed [8:0]      coil_b_current,
    output logic                   index_out,
    output logic                   power_stage_on,
    output logic                   coil_freewheel,
    output logic                   coil_brake,
    output logic                   chopper_cycle_mode,
    output logic                   clock_source_ext,
    output logic      [9:0]        microstep_position
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (VEL_W < 8 || VEL_W > 31)
    begin : g_bad_vel
        $error("VEL_W must lie between 8 and 31");
    end
    if (EXT_TIMEOUT < 2 || EXT_TIMEOUT > 65535)
    begin : g_bad_tmo
        $error("EXT_TIMEOUT must lie between 2 and 65535");
    end

    // ****************************************************************
    // Quarter-wave sine table, 64 entries, full scale 248.
    // ****************************************************************
    localparam logic [7:0] SINE_TAB [64] = '{
        8'h00, 8'h06, 8'h0C, 8'h12, 8'h18, 8'h1E, 8'h24, 8'h2A,
        8'h30, 8'h36, 8'h3C, 8'h42, 8'h48, 8'h4E, 8'h54, 8'h59,
        8'h5F, 8'h64, 8'h6A, 8'h6F, 8'h74, 8'h7A, 8'h7F, 8'h84,
        8'h8A, 8'h8E, 8'h93, 8'h98, 8'h9C, 8'hA1, 8'hA6, 8'hAA,
        8'hAF, 8'hB3, 8'hB7, 8'hBB, 8'hBF, 8'hC3, 8'hC7, 8'hCA,
        8'hCE, 8'hD1, 8'hD4, 8'hD7, 8'hDA, 8'hDD, 8'hE0, 8'hE2,
        8'hE5, 8'hE7, 8'hE9, 8'hEB, 8'hED, 8'hEF, 8'hF1, 8'hF2,
        8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF6, 8'hF7, 8'hF7, 8'hF8
    };

    // Signed wave value for a 10-bit electrical angle, scaled by (scale+1)/32.
    function automatic logic signed [8:0] wave(input logic [9:0] ang, input logic [4:0] scale);
        logic [7:0]  ph;
        logic [7:0]  mag;
        logic [12:0] prod;
        ph   = ang[8] ? (8'hFF - ang[7:0]) : ang[7:0];
        mag  = SINE_TAB[ph[7:2]];
        prod = 13'(mag) * 13'({1'b0, scale} + 6'h01);
        wave = ang[9] ? -$signed({1'b0, prod[12:5]}) : $signed({1'b0, prod[12:5]});
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed
    {
        logic [1:0]         step_sync;
        logic [1:0]         dir_sync;
        logic [1:0]         pdn_sync;
        logic [1:0]         dis_sync;
        logic [1:0]         ms0_sync;
        logic [1:0]         ms1_sync;
        logic [1:0]         chop_sync;
        logic [1:0]         clk_sync;
        logic               step_last;
        logic               clk_last;
        logic [15:0]        clk_idle;
        logic               ext_ok;
        logic               serial_en;
        logic [11:0]        cfg;
        logic [VEL_W-1:0]   velocity;
        logic [31:0]        current;
        logic [VEL_W-1:0]   accum;
        logic [9:0]         position;
        logic [23:0]        still_cnt;
        logic               standstill;
        logic [4:0]         scale;
        logic [15:0]        decay_cnt;
        logic [31:0]        rdata;
        logic signed [8:0]  coil_a;
        logic signed [8:0]  coil_b;
        logic               index;
        logic               stage_on;
        logic               freewheel;
        logic               brake;
        logic               chop;
    } sds_state_t;

    sds_state_t st_reg;
    sds_state_t st_next;

    // ****************************************************************
    // Combinational next state.
    // ****************************************************************
    always_comb
    begin
        logic               step_edge;
        logic               ext_step;
        logic               int_step;
        logic               do_step;
        logic               step_down;
        logic [3:0]         mres;
        logic [9:0]         step_size;
        logic [VEL_W-1:0]   vel_mag;
        logic [VEL_W:0]     acc_sum;
        logic               node_hit;
        logic               pins_locked;
        logic               reduce_on;
        logic [4:0]         run_scale;
        logic [4:0]         hold_scale;
        logic [23:0]        delay_cyc;
        logic [15:0]        decay_cyc;
        logic [9:0]         new_pos;
        step_edge   = 1'b0;
        ext_step    = 1'b0;
        int_step    = 1'b0;
        do_step     = 1'b0;
        step_down   = 1'b0;
        mres        = sds_pkg::RST_MRES;
        step_size   = 10'h001;
        vel_mag     = '0;
        acc_sum     = '0;
        node_hit    = 1'b0;
        pins_locked = 1'b0;
        reduce_on   = 1'b0;
        run_scale   = '0;
        hold_scale  = '0;
        delay_cyc   = '0;
        decay_cyc   = '0;
        new_pos     = '0;
        st_next     = st_reg;

        // Every pin and the external clock pass two flip-flops first.
        st_next.step_sync = {st_reg.step_sync[0], step_in};
        st_next.dir_sync  = {st_reg.dir_sync[0], dir_in};
        st_next.pdn_sync  = {st_reg.pdn_sync[0], powerdown_serial_pin};
        st_next.dis_sync  = {st_reg.dis_sync[0], driver_disable_n};
        st_next.ms0_sync  = {st_reg.ms0_sync[0], resolution_select_0};
        st_next.ms1_sync  = {st_reg.ms1_sync[0], resolution_select_1};
        st_next.chop_sync = {st_reg.chop_sync[0], chopper_select_pin};
        st_next.clk_sync  = {st_reg.clk_sync[0], ext_clk_in};
        st_next.step_last = st_reg.step_sync[1];
        st_next.clk_last  = st_reg.clk_sync[1];

        // ************************************************************
        // External clock watchdog.
        // ************************************************************
        if (st_reg.clk_sync[1] != st_reg.clk_last)
        begin
            st_next.clk_idle = '0;
            st_next.ext_ok   = 1'b1;
        end
        else if (st_reg.clk_idle >= 16'(EXT_TIMEOUT - 1))
        begin
            st_next.ext_ok = 1'b0;
        end
        else
        begin
            st_next.clk_idle = st_reg.clk_idle + 16'h0001;
        end

        // ************************************************************
        // Register port. The select pins double as the node address.
        // ************************************************************
        pins_locked = st_reg.serial_en && st_reg.cfg[sds_pkg::CFG_PIN_DISABLE];
        node_hit    = (bus_node == {st_reg.ms1_sync[1], st_reg.ms0_sync[1]});
        st_next.rdata = '0;
        if (bus_wr && node_hit)
        begin
            st_next.serial_en = 1'b1;
            unique case (bus_addr)
                sds_pkg::REG_CONFIG:   st_next.cfg = bus_wdata[11:0];
                sds_pkg::REG_VELOCITY: st_next.velocity = bus_wdata[VEL_W-1:0];
                sds_pkg::REG_CURRENT:  st_next.current = bus_wdata;
                default:               st_next.serial_en = 1'b1;
            endcase
        end
        if (bus_rd && node_hit)
        begin
            unique case (bus_addr)
                sds_pkg::REG_CONFIG:   st_next.rdata = 32'(st_reg.cfg);
                sds_pkg::REG_VELOCITY: st_next.rdata = 32'(st_reg.velocity);
                sds_pkg::REG_CURRENT:  st_next.rdata = st_reg.current;
                sds_pkg::REG_STATUS:
                begin
                    st_next.rdata = 32'(st_reg.position);
                    st_next.rdata[sds_pkg::STA_EXT_CLK]    = st_reg.ext_ok;
                    st_next.rdata[sds_pkg::STA_SERIAL_EN]  = st_reg.serial_en;
                    st_next.rdata[sds_pkg::STA_STANDSTILL] = st_reg.standstill;
                    st_next.rdata[sds_pkg::STA_POWER_ON]   = st_reg.stage_on;
                end
                default:               st_next.rdata = '0;
            endcase
        end

        // ************************************************************
        // Resolution select.
        // ************************************************************
        if (pins_locked)
        begin
            mres = st_reg.cfg[sds_pkg::CFG_MRES_LSB +: 4];
            if (mres > sds_pkg::MRES_FULL)
            begin
                mres = sds_pkg::MRES_FULL;
            end
        end
        else
        begin
            unique case ({st_reg.ms1_sync[1], st_reg.ms0_sync[1]})
                2'b00: mres = 4'h5;
                2'b01: mres = 4'h3;
                2'b10: mres = 4'h2;
                2'b11: mres = 4'h4;
            endcase
        end
        step_size = 10'h001 << mres;

        // ************************************************************
        // Step sources.
        // ************************************************************
        step_edge = st_reg.cfg[sds_pkg::CFG_DOUBLE_EDGE]
                  ? (st_reg.step_sync[1] != st_reg.step_last)
                  : (st_reg.step_sync[1] && !st_reg.step_last);
        vel_mag = st_reg.velocity[VEL_W-1] ? (~st_reg.velocity + 1'b1) : st_reg.velocity;
        if (st_reg.velocity == '0)
        begin
            st_next.accum = '0;
            ext_step  = step_edge;
            step_down = st_reg.dir_sync[1];
        end
        else
        begin
            // Rate is clock * |velocity| / 2^VEL_W; the fractional part carries over.
            acc_sum       = {1'b0, st_reg.accum} + {1'b0, vel_mag};
            st_next.accum = acc_sum[VEL_W-1:0];
            int_step      = acc_sum[VEL_W];
            step_down     = st_reg.velocity[VEL_W-1];
        end
        do_step = ext_step || int_step;
        new_pos = step_down ? (st_reg.position - step_size) : (st_reg.position + step_size);
        if (do_step)
        begin
            st_next.position = new_pos;
        end

        // ************************************************************
        // Standstill handling.
        // ************************************************************
        run_scale  = st_reg.current[sds_pkg::CUR_RUN_LSB +: 5];
        hold_scale = st_reg.current[sds_pkg::CUR_HOLD_LSB +: 5];
        delay_cyc  = 24'(st_reg.current[sds_pkg::CUR_DELAY_LSB +: 8]) * 24'(sds_pkg::DELAY_UNIT_CYC);
        decay_cyc  = 16'(st_reg.current[sds_pkg::CUR_DECAY_LSB +: 4]) * 16'(sds_pkg::DECAY_UNIT_CYC);
        reduce_on  = !st_reg.pdn_sync[1]
                  && !(st_reg.serial_en && st_reg.cfg[sds_pkg::CFG_PDN_DISABLE]);
        if (do_step || !reduce_on)
        begin
            st_next.still_cnt  = '0;
            st_next.standstill = 1'b0;
            st_next.scale      = run_scale;
            st_next.decay_cnt  = '0;
        end
        else if (!st_reg.standstill)
        begin
            st_next.still_cnt = st_reg.still_cnt + 24'h000001;
            if (st_reg.still_cnt >= delay_cyc)
            begin
                st_next.standstill = 1'b1;
            end
        end
        else if (st_reg.scale > hold_scale)
        begin
            // Ramp down one scale step per decay interval to avoid a current jolt.
            if (st_reg.decay_cnt >= decay_cyc)
            begin
                st_next.decay_cnt = '0;
                st_next.scale     = st_reg.scale - 5'h01;
            end
            else
            begin
                st_next.decay_cnt = st_reg.decay_cnt + 16'h0001;
            end
        end
        else
        begin
            st_next.scale = hold_scale;
        end

        st_next.freewheel = st_reg.standstill
                         && (st_reg.cfg[sds_pkg::CFG_STILL_LSB +: 2] == 2'(sds_pkg::STILL_FREEWHEEL));
        st_next.brake     = st_reg.standstill
                         && (st_reg.cfg[sds_pkg::CFG_STILL_LSB +: 2] == 2'(sds_pkg::STILL_BRAKE));
        st_next.stage_on  = !st_reg.dis_sync[1];
        st_next.chop      = st_reg.cfg[sds_pkg::CFG_CHOP_CYCLE]
                         || (!pins_locked && st_reg.chop_sync[1]);

        // ************************************************************
        // Coil set-points and index.
        // ************************************************************
        st_next.coil_a = wave(st_reg.position, st_reg.scale);
        st_next.coil_b = wave(st_reg.position + 10'h100, st_reg.scale);
        st_next.index  = (st_reg.position < step_size);
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg          <= '0;
            st_reg.position <= sds_pkg::RST_POSITION;
            st_reg.scale    <= sds_pkg::RST_RUN_SCALE;
            st_reg.current  <= {sds_pkg::RST_DECAY, 4'h0, sds_pkg::RST_DELAY, 3'h0,
                                sds_pkg::RST_HOLD_SCALE, 3'h0, sds_pkg::RST_RUN_SCALE};
            st_reg.cfg      <= {8'h00, sds_pkg::RST_MRES};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata          = st_reg.rdata;
    assign coil_a_current     = st_reg.coil_a;
    assign coil_b_current     = st_reg.coil_b;
    assign index_out          = st_reg.index;
    assign power_stage_on     = st_reg.stage_on;
    assign coil_freewheel     = st_reg.freewheel;
    assign coil_brake         = st_reg.brake;
    assign chopper_cycle_mode = st_reg.chop;
    assign clock_source_ext   = st_reg.ext_ok;
    assign microstep_position = st_reg.position;

endmodule

// file: verif/sds_checker.sv
`timescale 1ns/1ps
module sds_checker
#(
    parameter int EXT_TIMEOUT = 32
)
(
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    input wire logic              driver_disable_n,
    input wire logic              chopper_select_pin,
    input wire logic              ext_clk_in,
    input wire logic              power_stage_on,
    input wire logic              index_out,
    input wire logic              coil_freewheel,
    input wire logic              coil_brake,
    input wire logic              chopper_cycle_mode,
    input wire logic              clock_source_ext,
    input wire logic signed [8:0] coil_a_current,
    input wire logic signed [8:0] coil_b_current,
    input wire logic [9:0]        microstep_position
);
    // ************************
    // Cycles since the external clock moved.
    // ************************
    logic [7:0] quiet_cnt;
    logic       ext_last;
    always_ff @(posedge ref_clk)
    begin
        ext_last <= ext_clk_in;
        if (sys_rst || (ext_clk_in != ext_last))
            quiet_cnt <= 8'h00;
        else if (quiet_cnt != 8'hFF)
            quiet_cnt <= quiet_cnt + 8'h01;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Pins pass a two-stage synchroniser, so levels are judged after four steady samples.
    stage_follows_a: assert property ($stable(driver_disable_n) [*4] |-> power_stage_on == !driver_disable_n)
        else $error("stage ignores disable pin");
    pos_reset_a: assert property ($fell(sys_rst) |-> microstep_position == 10'h000)
        else $error("position not zero");
    index_zero_a: assert property (!sys_rst && microstep_position == 10'h000 |=> index_out)
        else $error("index low at zero");
    index_far_a: assert property (microstep_position[9:8] != 2'h0 |=> !index_out)
        else $error("index high off zero");
    sine_zero_a: assert property (microstep_position == 10'h000 |=> coil_a_current == 9'sh000)
        else $error("sine not zero");
    cosine_zero_a: assert property (microstep_position == 10'h100 |=> coil_b_current == 9'sh000)
        else $error("cosine not zero");
    ext_drop_a: assert property (quiet_cnt > EXT_TIMEOUT + 4 |-> !clock_source_ext)
        else $error("ext clock kept");
    chop_pin_a: assert property (chopper_select_pin [*4] |-> chopper_cycle_mode)
        else $error("chopper pin ignored");
    still_mode_a: assert property (coil_freewheel |-> !coil_brake)
        else $error("freewheel with brake");
endmodule

// file: verif/sds_host_model.sv
`timescale 1ns/1ps
module sds_host_model
(
    input  wire logic ref_clk,
    input  wire logic fire,
    input  wire logic dir_req,
    output logic      step_in,
    output logic      dir_in
);
    logic [1:0] lead_cnt;
    initial
    begin
        step_in = 1'b0;
        dir_in = 1'b0;
        lead_cnt = 2'h0;
    end
    // ************************
    // Each request turns the step line over once.
    // ************************
    // Direction leads the step edge by three cycles so the synchroniser sees it settled.
    always @(posedge ref_clk)
    begin
        if (fire)
        begin
            dir_in <= dir_req;
            lead_cnt <= 2'h3;
        end
        else if (lead_cnt != 2'h0)
        begin
            lead_cnt <= lead_cnt - 2'h1;
            if (lead_cnt == 2'h1)
                step_in <= ~step_in;
        end
    end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int EXT_TO = 16;
    logic ref_clk, sys_rst, step_in, dir_in, fire, dir_req, bus_wr, bus_rd, ext_clk_in;
    logic powerdown_serial_pin, driver_disable_n, resolution_select_0, resolution_select_1, chopper_select_pin;
    logic index_out, power_stage_on, coil_freewheel, coil_brake, chopper_cycle_mode, clock_source_ext;
    logic [1:0]        bus_node;
    logic [3:0]        bus_addr;
    logic [31:0]       bus_wdata, bus_rdata, rd_val, cfg_shadow;
    logic signed [8:0] coil_a_current, coil_b_current;
    logic [9:0]        microstep_position, pos_seen;
    int                err_count;
    int                compares;
    int                cycles;

    sds_sequencer #(.EXT_TIMEOUT(EXT_TO)) u_dut (.ref_clk, .sys_rst, .step_in, .dir_in, .powerdown_serial_pin,
        .driver_disable_n, .resolution_select_0, .resolution_select_1, .chopper_select_pin, .ext_clk_in,
        .bus_node, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .coil_a_current, .coil_b_current,
        .index_out, .power_stage_on, .coil_freewheel, .coil_brake, .chopper_cycle_mode, .clock_source_ext,
        .microstep_position);
    sds_host_model u_host (.ref_clk, .fire, .dir_req, .step_in, .dir_in);

    // ************************
    // Shared tasks.
    // ************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {bus_wr, bus_addr, bus_wdata, bus_node} <= {1'b1, a, d, 2'h0};
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] n, input logic [3:0] a);
        @(posedge ref_clk);
        {bus_rd, bus_addr, bus_node} <= {1'b1, a, n};
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = bus_rdata;
    endtask
    task automatic step(input logic d);
        @(posedge ref_clk);
        {fire, dir_req} <= {1'b1, d};
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask

    // ************************
    // Scenarios.
    // ************************
    task automatic t_pins;
        logic [9:0] size [4] = '{10'h020, 10'h008, 10'h004, 10'h010};
        for (int i = 0; i < 4; i++)
        begin
            {resolution_select_1, resolution_select_0} <= 2'(i);
            repeat (4) @(posedge ref_clk);
            step(1'b0);
            step(1'b0);
            check("pin_step", microstep_position, size[i]);
            step(1'b1);
            step(1'b1);
            check("pin_back", microstep_position, 10'h000);
        end
        {resolution_select_1, resolution_select_0} <= 2'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_sweep;
        rd(2'h0, sds_pkg::REG_STATUS);
        check("status_idle", rd_val, 32'h00080000);
        for (int c = 0; c <= 8; c++)
        begin
            cfg_shadow = 32'h3 | (32'(c) << sds_pkg::CFG_MRES_LSB);
            wr(sds_pkg::REG_CONFIG, cfg_shadow);
            step(1'b0);
            step(1'b0);
            check("res_step", microstep_position, 10'h002 << c);
            step(1'b1);
            step(1'b1);
            check("res_back", microstep_position, 10'h000);
        end
        rd(2'h0, sds_pkg::REG_STATUS);
        check("serial_on", rd_val[sds_pkg::STA_SERIAL_EN], 1'b1);
        rd(2'h1, sds_pkg::REG_STATUS);
        check("other_node", rd_val, 32'h0);
    endtask
    task automatic t_still;
        check("run_level", coil_b_current, 32'h0F8);
        wr(sds_pkg::REG_CURRENT, 32'h0201101F);
        powerdown_serial_pin <= 1'b0;
        repeat (5000) @(posedge ref_clk);
        check("hold_level", coil_b_current, 32'h083);
        rd(2'h0, sds_pkg::REG_STATUS);
        check("still_flag", rd_val[sds_pkg::STA_STANDSTILL], 1'b1);
        for (int m = 1; m <= 2; m++)
        begin
            cfg_shadow[9:8] = 2'(m);
            wr(sds_pkg::REG_CONFIG, cfg_shadow);
            repeat (3) @(posedge ref_clk);
            check("freewheel", coil_freewheel, m == 1);
            check("brake", coil_brake, m == 2);
        end
        wr(sds_pkg::REG_CONFIG, 32'h0);
        powerdown_serial_pin <= 1'b1;
    endtask
    task automatic t_vel;
        // One carry every sixteen cycles; the write latency blurs the count by one step.
        wr(sds_pkg::REG_VELOCITY, 32'h00100000);
        repeat (160) @(posedge ref_clk);
        check("vel_fwd", microstep_position inside {[10'h120:10'h160]}, 1'b1);
        wr(sds_pkg::REG_VELOCITY, 32'h00F00000);
        repeat (160) @(posedge ref_clk);
        check("vel_back", (microstep_position + 10'h040) <= 10'h080, 1'b1);
        wr(sds_pkg::REG_VELOCITY, 32'h0);
        repeat (4) @(posedge ref_clk);
        pos_seen = microstep_position;
        step(1'b0);
        check("ext_again", microstep_position, pos_seen + 10'h020);
        step(1'b0);
    endtask
    task automatic t_misc;
        check("ext_idle", clock_source_ext, 1'b0);
        repeat (20) @(posedge ref_clk) ext_clk_in <= ~ext_clk_in;
        check("ext_alive", clock_source_ext, 1'b1);
        repeat (EXT_TO + 8) @(posedge ref_clk);
        check("ext_lost", clock_source_ext, 1'b0);
        {driver_disable_n, chopper_select_pin} <= 2'h3;
        repeat (5) @(posedge ref_clk);
        check("stage_off", power_stage_on, 1'b0);
        check("chop_pin", chopper_cycle_mode, 1'b1);
        {driver_disable_n, chopper_select_pin} <= 2'h0;
        repeat (5) @(posedge ref_clk);
        check("stage_on", power_stage_on, 1'b1);
        check("chop_off", chopper_cycle_mode, 1'b0);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            close_out;
        end
    end
    initial
    begin
        {sys_rst, fire, dir_req, bus_wr, bus_rd, ext_clk_in, driver_disable_n, chopper_select_pin} = 8'h80;
        {resolution_select_0, resolution_select_1, powerdown_serial_pin, bus_node, bus_addr} = 9'h040;
        {bus_wdata, cfg_shadow} = 64'h0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("pos_reset", microstep_position, 10'h000);
        check("cos_reset", coil_b_current, 32'h0F8);
        t_pins;
        t_sweep;
        t_still;
        t_vel;
        t_misc;
        close_out;
    end
endmodule

bind sds_sequencer sds_checker #(.EXT_TIMEOUT(EXT_TIMEOUT)) u_chk (.ref_clk, .sys_rst, .driver_disable_n,
    .chopper_select_pin, .ext_clk_in, .power_stage_on, .index_out, .coil_freewheel, .coil_brake,
    .chopper_cycle_mode, .clock_source_ext, .coil_a_current, .coil_b_current, .microstep_position);
